/* rtl/mode_seq.sv */
`timescale 1ns/1ps
`default_nettype none
module mode_seq
    import mode_seq_pkg::*;
(
    // clock and control
    input wire logic clock,
    input wire logic srst,
    input wire logic ce,
    // system sense
    input wire logic power_good,
    input wire logic strap_inst,
    input wire logic strap_ground,
    input wire logic ground_test_equipment_cmd,
    input wire logic unit_init_done,
    input wire logic frame_done,
    input wire logic results_sent,
    input wire logic table_loaded,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // actuation
    output ctl_type ctl_q,
    output logic housekeeping_req_q,
    output logic capture_frame_q,
    output logic compute_start_q,
    output logic sw_load_en_q
);

    // ******************************
    // helpers
    // ******************************
    function automatic logic idle_target(input logic [3:0] c);
        return c inside {cmd_prime, cmd_fast, cmd_offvar, cmd_diag,
            cmd_anneal, cmd_deice, cmd_decont, cmd_iftest};
    endfunction : idle_target

    function automatic mode_type code_mode(input logic [3:0] c);
        unique case (c)
            cmd_prime: return m_prime;
            cmd_fast: return m_fast;
            cmd_offvar: return m_offvar;
            cmd_diag: return m_diag;
            cmd_anneal: return m_anneal;
            cmd_deice: return m_deice;
            cmd_decont: return m_decont;
            default: return m_iftest;
        endcase
    endfunction : code_mode

    typedef enum logic [1:0] {ov_discard, ov_compute, ov_send, ov_wait}
        ov_type;

    // ******************************
    // state
    // ******************************
    mode_type mode_q, mode_d;
    ov_type ov_q, ov_d;
    ctl_type ctl_d;
    logic sci_q, sci_d;
    logic inst_q, inst_d;
    logic pwr_q;
    logic [7:0] discard_q, discard_d, left_q, left_d;
    logic [2:0] ccd_q, ccd_d;
    logic [15:0] reject_q, reject_d;
    logic [15:0] hk_cnt_q, hk_cnt_d;
    logic hk_d, cap_d, comp_d, swl_d, init_hk_q, init_hk_d;
    logic [31:0] rdata_d;
    logic ack_d;
    tc_type tc;
    logic acc;

    assign tc.valid = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
        && wb_adr_i == reg_cmd && wb_sel_i[0];
    assign tc.emergency = wb_dat_i[cmd_emerg_bit];
    assign tc.code = wb_dat_i[cmd_code_lsb +: 4];
    assign tc.ccd = wb_dat_i[cmd_ccd_lsb +: 3];
    assign tc.discard = wb_dat_i[cmd_discard_lsb +: 8];

    // ******************************
    // next state
    // ******************************
    always_comb begin
        mode_d = mode_q;
        ov_d = ov_q;
        ctl_d = ctl_q;
        sci_d = sci_q;
        inst_d = inst_q;
        discard_d = discard_q;
        left_d = left_q;
        ccd_d = ccd_q;
        reject_d = reject_q;
        hk_d = 1'b0;
        cap_d = 1'b0;
        comp_d = 1'b0;
        swl_d = 1'b0;
        init_hk_d = init_hk_q;
        acc = 1'b0;
        hk_cnt_d = hk_cnt_q + 16'h0001;
        if (hk_cnt_q == hk_period_cyc) begin
            hk_cnt_d = 16'h0000;
            // periodic housekeeping in standby and idle
            if (mode_q == m_standby || mode_q == m_idle) begin
                hk_d = 1'b1;
            end
        end
        unique case (mode_q)
            m_off: begin
                if (pwr_q) begin
                    mode_d = m_init;
                    init_hk_d = 1'b0;
                end
            end
            m_init: begin
                if (unit_init_done && !init_hk_q) begin
                    init_hk_d = 1'b1;
                    hk_d = 1'b1;
                    inst_d = strap_inst;
                    mode_d = strap_ground ? m_ground : m_standby;
                end
            end
            m_standby: begin
                ctl_d.wheel_closed = 1'b1;
                ctl_d.heaters_on = 1'b0;
                ctl_d.ccd_setpoint = standby_setpoint;
                if (tc.valid) begin
                    acc = 1'b1;
                    if (tc.code == cmd_idle) begin
                        mode_d = m_idle;
                    end else if (tc.code == cmd_off) begin
                        mode_d = m_off;
                    end else if (tc.code == cmd_door_vent && !sci_q) begin
                        ctl_d.door_open = 1'b1;
                        ctl_d.vent_open = 1'b1;
                        sci_d = 1'b1;
                    end else if (tc.code == cmd_sw_load && sci_q) begin
                        swl_d = 1'b1;
                    end else begin
                        acc = 1'b0;
                    end
                end
            end
            m_idle: begin
                if (tc.valid) begin
                    acc = 1'b1;
                    if (tc.code == cmd_standby) begin
                        mode_d = m_standby;
                    end else if (tc.code == cmd_config) begin
                        ctl_d.active_ccd = tc.ccd;
                        ctl_d.threshold_mode = tc.emergency;
                    end else if (idle_target(tc.code) && sci_q) begin
                        mode_d = code_mode(tc.code);
                        if (tc.code == cmd_offvar) begin
                            if (tc.discard != 8'h00) begin
                                discard_d = tc.discard;
                            end
                            ccd_d = tc.ccd;
                            left_d = tc.discard == 8'h00 ? discard_q
                                : tc.discard;
                            ov_d = ov_discard;
                        end
                    end else begin
                        acc = 1'b0;
                    end
                end
            end
            m_ground: begin
                if (ground_test_equipment_cmd) begin
                    mode_d = m_standby;
                end
            end
            m_offvar: begin
                unique case (ov_q)
                    ov_discard: begin
                        if (frame_done) begin
                            if (left_q == 8'h00) begin
                                ov_d = ov_compute;
                                comp_d = 1'b1;
                            end else begin
                                left_d = left_q - 8'h01;
                            end
                        end
                        cap_d = left_q == 8'h00;
                    end
                    ov_compute: ov_d = ov_send;
                    ov_send: begin
                        if (results_sent) begin
                            ov_d = ov_wait;
                        end
                    end
                    ov_wait: begin
                        if (table_loaded) begin
                            mode_d = m_idle;
                        end
                    end
                endcase
                if (tc.valid) begin
                    acc = 1'b1;
                    if (tc.code == cmd_idle) begin
                        mode_d = m_idle;
                    end else if (tc.code == cmd_standby && tc.emergency) begin
                        mode_d = m_standby;
                    end else if (tc.code == cmd_repeat && ov_q == ov_wait) begin
                        ccd_d = tc.ccd;
                        left_d = discard_q;
                        ov_d = ov_discard;
                    end else begin
                        acc = 1'b0;
                    end
                end
            end
            default: begin
                // other science modes: idle or emergency standby only
                if (tc.valid) begin
                    acc = 1'b1;
                    if (tc.code == cmd_idle) begin
                        mode_d = m_idle;
                    end else if (tc.code == cmd_standby && tc.emergency) begin
                        mode_d = m_standby;
                    end else begin
                        acc = 1'b0;
                    end
                end
            end
        endcase
        if (mode_q == m_offvar || ctl_q.threshold_mode) begin
            ctl_d.active_ccd = mode_q == m_offvar ? ccd_q
                : ctl_d.active_ccd;
        end
        if (!pwr_q && mode_q != m_off) begin
            mode_d = m_off;
        end
        if (tc.valid && !acc) begin
            reject_d = reject_q + 16'h0001;
        end
    end

    // ******************************
    // bus read and ack
    // ******************************
    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (wb_adr_i)
            reg_status: begin
                rdata_d[st_mode_lsb +: 4] = mode_q;
                rdata_d[st_sci_bit] = sci_q;
                rdata_d[st_inst_bit] = inst_q;
                rdata_d[st_door_bit] = ctl_q.door_open;
                rdata_d[st_vent_bit] = ctl_q.vent_open;
                rdata_d[st_wheel_bit] = ctl_q.wheel_closed;
                rdata_d[st_heat_bit] = ctl_q.heaters_on;
                rdata_d[st_ov_busy_bit] = mode_q == m_offvar;
                rdata_d[st_thr_bit] = ctl_q.threshold_mode;
                rdata_d[st_ccd_lsb +: 3] = ctl_q.active_ccd;
            end
            reg_config: rdata_d[7:0] = discard_q;
            reg_reject: rdata_d[15:0] = reject_q;
            default: rdata_d = 32'h0000_0000;
        endcase
        ack_d = wb_cyc_i && wb_stb_i && !wb_ack_o;
    end

    // ******************************
    // registers
    // ******************************
    always_ff @(posedge clock) begin
        if (srst) begin
            mode_q <= m_off;
            ov_q <= ov_discard;
            ctl_q <= '{wheel_closed: 1'b1, heaters_on: 1'b0,
                door_open: 1'b0, vent_open: 1'b0,
                ccd_setpoint: standby_setpoint, active_ccd: 3'h0,
                threshold_mode: 1'b0};
            sci_q <= 1'b0;
            inst_q <= 1'b0;
            pwr_q <= 1'b0;
            discard_q <= discard_reset;
            left_q <= 8'h00;
            ccd_q <= 3'h0;
            reject_q <= 16'h0000;
            hk_cnt_q <= 16'h0000;
            housekeeping_req_q <= 1'b0;
            capture_frame_q <= 1'b0;
            compute_start_q <= 1'b0;
            sw_load_en_q <= 1'b0;
            init_hk_q <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            wb_ack_o <= 1'b0;
        end else if (ce) begin
            mode_q <= mode_d;
            ov_q <= ov_d;
            ctl_q <= ctl_d;
            sci_q <= sci_d;
            inst_q <= inst_d;
            pwr_q <= power_good;
            discard_q <= discard_d;
            left_q <= left_d;
            ccd_q <= ccd_d;
            reject_q <= reject_d;
            hk_cnt_q <= hk_cnt_d;
            housekeeping_req_q <= hk_d;
            capture_frame_q <= cap_d;
            compute_start_q <= comp_d;
            sw_load_en_q <= swl_d;
            init_hk_q <= init_hk_d;
            wb_dat_o <= rdata_d;
            wb_ack_o <= ack_d;
        end
    end

endmodule : mode_seq
`default_nettype wire

/* include/mode_seq_pkg.sv */
// Contract
// - science phase offers ten engineering modes
// - launch phase allows off, init, standby, idle
// - extra on-ground test mode exists
// - init entered only from off on power
// - gather init results, queue one housekeeping packet
// - flight instance sensed from test plug strap
// - init ends in standby, or ground test
// - standby entry paths; others need emergency
// - standby: wheel closed, ccd -130, heaters off
// - standby makes periodic housekeeping by default
// - launch: door/valve only in standby, then science
// - leave standby to off/idle; wheel untouched
// - science standby accepts software load/patch/dump
// - idle reachable except from off/init/ground test
// - idle runs config at once, periodic housekeeping
// - idle exits by command to nine modes
// - offset/variance only from idle, one ccd full
// - discard n>0 frames, capture one, compute
// - store, transmit results, then await command
// - offset/variance accepts only idle and standby (code also accepts repeat while awaiting the table)
// - auto idle when done; idle aborts anytime
// - threshold config: raw pixels, one ccd active
package mode_seq_pkg;

    typedef enum logic [3:0] {
        m_off, m_init, m_standby, m_idle, m_offvar, m_diag, m_anneal,
        m_deice, m_decont, m_iftest, m_ground, m_prime, m_fast
    } mode_type;

    // telecommand codes
    localparam logic [3:0] cmd_idle = 4'h1;
    localparam logic [3:0] cmd_standby = 4'h2;
    localparam logic [3:0] cmd_off = 4'h3;
    localparam logic [3:0] cmd_prime = 4'h4;
    localparam logic [3:0] cmd_fast = 4'h5;
    localparam logic [3:0] cmd_offvar = 4'h6;
    localparam logic [3:0] cmd_diag = 4'h7;
    localparam logic [3:0] cmd_anneal = 4'h8;
    localparam logic [3:0] cmd_deice = 4'h9;
    localparam logic [3:0] cmd_decont = 4'ha;
    localparam logic [3:0] cmd_iftest = 4'hb;
    localparam logic [3:0] cmd_config = 4'hc;
    localparam logic [3:0] cmd_sw_load = 4'hd;
    localparam logic [3:0] cmd_door_vent = 4'he;
    localparam logic [3:0] cmd_repeat = 4'hf;

    // wishbone register byte offsets
    localparam logic [7:0] reg_cmd = 8'h00;
    localparam logic [7:0] reg_status = 8'h04;
    localparam logic [7:0] reg_config = 8'h08;
    localparam logic [7:0] reg_reject = 8'h0c;

    // command register fields
    localparam int cmd_code_lsb = 0;
    localparam int cmd_emerg_bit = 4;
    localparam int cmd_ccd_lsb = 8;
    localparam int cmd_discard_lsb = 16;

    // status register fields
    localparam int st_mode_lsb = 0;
    localparam int st_sci_bit = 4;
    localparam int st_inst_bit = 5;
    localparam int st_door_bit = 6;
    localparam int st_vent_bit = 7;
    localparam int st_wheel_bit = 8;
    localparam int st_heat_bit = 9;
    localparam int st_ov_busy_bit = 10;
    localparam int st_thr_bit = 11;
    localparam int st_ccd_lsb = 12;

    localparam logic [7:0] discard_reset = 8'h01;
    localparam logic signed [8:0] standby_setpoint = -9'sd130;
    localparam logic [15:0] hk_period_cyc = 16'h0fff;

    typedef struct packed {
        logic valid;
        logic emergency;
        logic [3:0] code;
        logic [2:0] ccd;
        logic [7:0] discard;
    } tc_type;

    typedef struct packed {
        logic wheel_closed;
        logic heaters_on;
        logic door_open;
        logic vent_open;
        logic signed [8:0] ccd_setpoint;
        logic [2:0] active_ccd;
        logic threshold_mode;
    } ctl_type;

endpackage : mode_seq_pkg

/* testbench/mode_seq_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ************
// mode checks
// ************
module mode_seq_checker
    import mode_seq_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    input wire logic ce,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    // sense and actuation
    input wire logic frame_done,
    input wire ctl_type ctl_q,
    input wire logic compute_start_q,
    input wire logic sw_load_en_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst || !ce);
    logic cmd_wr;
    assign cmd_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == reg_cmd;
    a_reset_safe: assert property (disable iff (!ce) srst |=>
        ctl_q.wheel_closed && ctl_q.ccd_setpoint == -9'sd130
        && !ctl_q.heaters_on)
        else $error("reset state not safe");
    a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("ack late");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_ack_cause: assert property (
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_swload_cause: assert property (sw_load_en_q |->
        $past(cmd_wr && wb_dat_i[3:0] == cmd_sw_load)
        || $past(cmd_wr && wb_dat_i[3:0] == cmd_sw_load, 2))
        else $error("load without command");
    a_swload_pulse: assert property (
        sw_load_en_q |=> !sw_load_en_q)
        else $error("load pulse long");
    a_compute_cause: assert property (compute_start_q |->
        $past(frame_done) || $past(frame_done, 2))
        else $error("compute without frame");
    a_compute_pulse: assert property (
        compute_start_q |=> !compute_start_q)
        else $error("compute pulse long");
    a_door_cause: assert property (
        $rose(ctl_q.door_open) |-> ctl_q.vent_open
        && ($past(cmd_wr && wb_dat_i[3:0] == cmd_door_vent)
        || $past(cmd_wr && wb_dat_i[3:0] == cmd_door_vent, 2)))
        else $error("door opened alone");
    c_write: cover property (wb_ack_o && wb_we_i);
    c_compute: cover property (compute_start_q);
    c_door: cover property ($rose(ctl_q.door_open));
endmodule : mode_seq_checker
bind mode_seq mode_seq_checker u_checker (.clock(clock), .srst(srst),
    .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .frame_done(frame_done), .ctl_q(ctl_q),
    .compute_start_q(compute_start_q), .sw_load_en_q(sw_load_en_q));
`default_nettype wire

/* testbench/dh_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ************
// host bus master
// ************
module dh_host_model (
    // clock
    input wire logic clock,
    // bus master
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [7:0] wb_adr_o,
    output logic [3:0] wb_sel_o,
    output logic [31:0] wb_dat_o,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_i
);
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o = 1'b0;
        wb_adr_o = 8'h00;
        wb_sel_o = 4'hf;
        wb_dat_o = 32'h0;
    end
    // one classic cycle, held until ack
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clock);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o <= w;
        wb_adr_o <= a;
        wb_dat_o <= d;
        do @(posedge clock); while (wb_ack_i !== 1'b1);
        q = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_we_o <= 1'b0;
        wb_dat_o <= ~d;
    endtask : xfer
endmodule : dh_host_model
`default_nettype wire

/* testbench/camera_engineering_mode_sequencer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module camera_engineering_mode_sequencer_tb_top;
    import mode_seq_pkg::*;
    logic clock = 1'b0, srst = 1'b1, power_good = 1'b0, strap_ground = 1'b0;
    logic unit_init_done = 1'b0, cyc, stb, we, ack, hk, swl, comp, cap;
    logic ce = 1'b1, strap_inst = 1'b1;
    logic [3:0] ev = 4'h0, sel;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, q;
    ctl_type ctl;
    int err_total = 0, checks = 0, cyc_n = 0, hk_n = 0, comp_n = 0, sw_n = 0;
    int rj = 0, n = 0;
    logic [3:0] codes [7] = '{4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'h4, 4'h5};
    logic [3:0] modes [7] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hb, 4'hc};
    // ************
    // design and host
    // ************
    mode_seq u_dut (.clock(clock), .srst(srst), .ce(ce),
        .power_good(power_good), .strap_inst(strap_inst),
        .strap_ground(strap_ground),
        .ground_test_equipment_cmd(ev[3]), .unit_init_done(unit_init_done),
        .frame_done(ev[0]), .results_sent(ev[1]), .table_loaded(ev[2]),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .ctl_q(ctl), .housekeeping_req_q(hk), .capture_frame_q(cap),
        .compute_start_q(comp), .sw_load_en_q(swl));
    dh_host_model u_host (.clock(clock), .wb_cyc_o(cyc), .wb_stb_o(stb),
        .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat),
        .wb_dat_i(rdat), .wb_ack_i(ack));
    initial forever #50 clock = ~clock;
    always @(posedge clock) begin
        cyc_n++;
        if (hk === 1'b1) hk_n++;
        if (comp === 1'b1) comp_n++;
        if (swl === 1'b1) sw_n++;
        if (cyc_n == 20000) begin
            err_total++;
            wrap_up();
        end
    end
    // ************
    // tasks
    // ************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic rd(input logic [7:0] a);
        u_host.xfer(1'b0, a, 32'h0, q);
    endtask : rd
    task automatic cmd(input logic [3:0] c, input logic e = 1'b0,
                       input logic [7:0] d = 8'h00);
        u_host.xfer(1'b1, reg_cmd, {8'h00, d, 5'h00, 3'h3, 3'h0, e, c}, q);
    endtask : cmd
    task automatic mode_is(input logic [3:0] m);
        for (int i = 0; i < 40; i++) begin
            rd(reg_status);
            if (q[3:0] === m) break;
        end
        check({28'h0, q[3:0]}, {28'h0, m});
    endtask : mode_is
    task automatic strobe(input int k);
        @(posedge clock);
        ev[k] <= 1'b1;
        @(posedge clock);
        ev[k] <= 1'b0;
        repeat (4) @(posedge clock);
    endtask : strobe
    task automatic wrap_up;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    // ************
    // scenarios
    // ************
    initial begin
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        cmd(cmd_idle);
        rj++;
        mode_is(4'h0);
        power_good <= 1'b1;
        unit_init_done <= 1'b1;
        mode_is(4'h2);
        rd(reg_status);
        check({26'h0, q[9:4]}, 32'h12);
        check(32'(hk_n > 0), 32'h1);
        n = hk_n;
        repeat (4200) @(posedge clock);
        check(32'(hk_n > n), 32'h1);
        cmd(cmd_idle);
        mode_is(4'h3);
        cmd(cmd_offvar);
        rj++;
        mode_is(4'h3);
        cmd(cmd_door_vent);
        rj++;
        mode_is(4'h3);
        cmd(cmd_standby);
        mode_is(4'h2);
        cmd(cmd_door_vent);
        rd(reg_status);
        check({28'h0, q[7:4]}, 32'hf);
        cmd(cmd_sw_load);
        repeat (3) @(posedge clock);
        check(sw_n, 32'h1);
        cmd(cmd_offvar);
        rj++;
        mode_is(4'h2);
        cmd(cmd_idle);
        for (int i = 0; i < 7; i++) begin
            cmd(codes[i]);
            mode_is(modes[i]);
            cmd(cmd_standby);
            rj++;
            mode_is(modes[i]);
            cmd(cmd_idle);
            mode_is(4'h3);
        end
        cmd(cmd_diag);
        cmd(cmd_standby, 1'b1);
        mode_is(4'h2);
        cmd(cmd_idle);
        cmd(cmd_offvar, 1'b0, 8'h02);
        rd(reg_status);
        check({28'h0, q[3:0]}, 32'h4);
        check({28'h0, q[14:12], q[10]}, 32'h7);
        cmd(cmd_diag);
        rj++;
        mode_is(4'h4);
        for (int r = 1; r <= 2; r++) begin
            strobe(0);
            strobe(0);
            check({31'h0, cap}, 32'h1);
            check(comp_n, r - 1);
            strobe(0);
            check({31'h0, cap}, 32'h0);
            check(comp_n, r);
            strobe(1);
            mode_is(4'h4);
            if (r == 1) cmd(cmd_repeat);
        end
        strobe(2);
        mode_is(4'h3);
        cmd(cmd_offvar);
        cmd(cmd_standby);
        rj++;
        mode_is(4'h4);
        cmd(cmd_standby, 1'b1);
        mode_is(4'h2);
        cmd(cmd_idle);
        cmd(cmd_offvar);
        cmd(cmd_idle);
        mode_is(4'h3);
        cmd(cmd_config, 1'b1);
        rd(reg_status);
        check({28'h0, q[14:11]}, 32'h7);
        n = hk_n;
        repeat (4200) @(posedge clock);
        check(32'(hk_n > n), 32'h1);
        rd(reg_reject);
        check(q, rj);
        rd(8'h10);
        check(q, 32'h0);
        strap_ground <= 1'b1;
        strap_inst <= 1'b0;
        srst <= 1'b1;
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        mode_is(4'ha);
        rd(reg_status);
        check({30'h0, q[5:4]}, 32'h0);
        cmd(cmd_idle);
        mode_is(4'ha);
        ce <= 1'b0;
        strobe(3);
        ce <= 1'b1;
        mode_is(4'ha);
        strobe(3);
        mode_is(4'h2);
        n = hk_n;
        cmd(cmd_off);
        mode_is(4'ha);
        rd(reg_status);
        check({31'h0, q[8]}, 32'h1);
        check(32'(hk_n > n), 32'h1);
        wrap_up();
    end
endmodule : camera_engineering_mode_sequencer_tb_top
`default_nettype wire
